// ===== verilog/rsc_pkg.sv
// constants and carrier types for the reset source combiner
// assumes a single 10 MHz system clock domain and a plain register port
package rsc_pkg;
    localparam int            RSC_AW            = 4;
    localparam logic [3:0]    RSC_ADDR_CAUSE    = 4'h0;
    localparam logic [3:0]    RSC_ADDR_CLKSEL   = 4'h1;
    localparam int            RSC_B_POR         = 0;
    localparam int            RSC_B_BOR         = 1;
    localparam int            RSC_B_IDLE        = 2;
    localparam int            RSC_B_SLEEP       = 3;
    localparam int            RSC_B_WATCHDOG_TIMEOUT_FLAG        = 4;
    localparam int            RSC_B_SOFT_WATCHDOG_ENABLE      = 5;
    localparam int            RSC_B_SWRST       = 6;
    localparam int            RSC_B_PIN         = 7;
    localparam int            RSC_B_FBIAS       = 8;
    localparam int            RSC_B_CFGMM       = 9;
    localparam int            RSC_B_DSLP        = 10;
    localparam int            RSC_B_ILLOP       = 14;
    localparam int            RSC_B_TRAP        = 15;
    localparam logic [15:0]   RSC_CAUSE_IMPL    = 16'hc7ff;
    localparam logic [15:0]   RSC_CAUSE_POR_VAL = 16'h0003;
    localparam int            RSC_OSC_W         = 3;
    localparam logic [2:0]    RSC_OSC_RST       = 3'h0;
    localparam int            RSC_CLK_HZ        = 10_000_000;
    localparam int            RSC_TPOR_US       = 10;
    localparam int            RSC_TPWRT_US      = 64_000;
    localparam int            RSC_TPOR_CYC      = (RSC_TPOR_US * (RSC_CLK_HZ / 1_000_000));
    localparam int            RSC_TPWRT_CYC     = (RSC_TPWRT_US * (RSC_CLK_HZ / 1_000_000));

    typedef struct packed {
        logic por;
        logic bor;
        logic pin;
        logic swrst;
        logic watchdog_timeout_flag;
        logic cfgmm;
        logic trap;
        logic illop;
        logic uninit_wreg_reset;
    } rsc_src_s;

    typedef struct packed {
        logic sleep;
        logic idle;
        logic deep_en;
    } rsc_psave_s;

    typedef enum logic [1:0] {
        RSC_ST_HOLD  = 2'b00,
        RSC_ST_POWER_UP_TIMER  = 2'b01,
        RSC_ST_RUN   = 2'b10
    } rsc_state_e;
endpackage

// ===== verilog/rsc_combiner.sv
// reset source combiner: master reset, cause register, reset-time clock pick
// assumes sources are synchronous levels or one-cycle pulses on clk_i
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rsc_combiner
    import rsc_pkg::*;
#(
    parameter int TPOR_CYC  = RSC_TPOR_CYC,
    parameter int TPWRT_CYC = RSC_TPWRT_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire rsc_src_s             src_i,
    input  wire rsc_psave_s           psave_i,
    input  wire logic                 power_up_timer_en_i,
    input  wire logic                 wdt_fuse_i,
    input  wire logic                 clk_switch_en_i,
    input  wire logic [RSC_OSC_W-1:0] new_osc_i,
    input  wire logic [RSC_OSC_W-1:0] cur_osc_i,
    input  wire logic [RSC_AW-1:0]    addr_i,
    input  wire logic [15:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [15:0]          rdata_o,
    output logic                      master_system_reset_o,
    output logic                      watchdog_enable_o,
    output logic                      flash_bias_in_sleep_o,
    output logic                      regulator_standby_o,
    output logic      [RSC_OSC_W-1:0] sys_osc_o
);
    // power-on is modelled by rst_i together with src_i.por
    logic              por_ev;
    logic              any_src;
    logic              wr_cause;
    logic [15:0]       hw_set;
    logic [15:0]       sw_val;
    logic [15:0]       cause_r;
    logic [15:0]       cause_nxt;
    logic [15:0]       rd_mux;
    logic [31:0]       cnt_r;
    logic [31:0]       cnt_nxt;
    logic              power_up_timer_phase;
    rsc_state_e        st_r;
    rsc_state_e        st_nxt;
    logic [RSC_OSC_W-1:0] osc_r;
    logic [RSC_OSC_W-1:0] osc_nxt;
    logic              por_seen_r;
    // helper state for the release checks only; never feeds the logic
    logic [31:0]       quiet_cnt_r;
    logic              arm_r;

    // power loss events are the only ones that arm the long release delays
    function automatic logic rsc_power_loss(input rsc_src_s s);
        return s.por | s.bor;
    endfunction

    assign por_ev  = src_i.por;
    assign any_src = |src_i;
    assign wr_cause = wr_i && (addr_i == RSC_ADDR_CAUSE);

    // hardware set terms, one per status cause bit; the soft watchdog enable and flash bias bits have none
    always_comb begin
        hw_set = 16'h0000;
        hw_set[RSC_B_POR]   = src_i.por;
        hw_set[RSC_B_BOR]   = src_i.por | src_i.bor;
        hw_set[RSC_B_PIN]   = src_i.pin;
        hw_set[RSC_B_SWRST] = src_i.swrst;
        hw_set[RSC_B_WATCHDOG_TIMEOUT_FLAG]  = src_i.watchdog_timeout_flag;
        hw_set[RSC_B_CFGMM] = src_i.cfgmm;
        hw_set[RSC_B_TRAP]  = src_i.trap;
        hw_set[RSC_B_ILLOP] = src_i.illop | src_i.uninit_wreg_reset;
        hw_set[RSC_B_SLEEP] = psave_i.sleep;
        hw_set[RSC_B_IDLE]  = psave_i.idle;
        hw_set[RSC_B_DSLP]  = psave_i.sleep & psave_i.deep_en;
    end

    // software value: deep-sleep bit is clear-only, unimplemented bits stay zero
    always_comb begin
        sw_val = wr_cause ? wdata_i : cause_r;
        sw_val[RSC_B_DSLP] = cause_r[RSC_B_DSLP] & (wr_cause ? wdata_i[RSC_B_DSLP] : 1'b1);
        if (psave_i.sleep || psave_i.idle) begin
            sw_val[RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
    end

    // set wins over a same-cycle clear; power-on reloads the fixed value
    assign cause_nxt = por_ev ? RSC_CAUSE_POR_VAL
                              : ((sw_val | hw_set) & RSC_CAUSE_IMPL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_r <= RSC_CAUSE_POR_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // release sequencer: after a power loss, power-on delay then power-up timer (when enabled) must expire; other resets go straight to run
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        power_up_timer_phase = 1'b0;
        unique case (st_r)
            RSC_ST_HOLD: begin
                if (any_src) begin
                    cnt_nxt = 32'h0;
                end else if (cnt_r >= 32'(TPOR_CYC - 1) || !por_seen_r) begin
                    cnt_nxt = 32'h0;
                    st_nxt  = (power_up_timer_en_i && por_seen_r) ? RSC_ST_POWER_UP_TIMER : RSC_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            RSC_ST_POWER_UP_TIMER: begin
                power_up_timer_phase = 1'b1;
                if (any_src) begin
                    st_nxt  = RSC_ST_HOLD;
                    cnt_nxt = 32'h0;
                end else if (cnt_r >= 32'(TPWRT_CYC - 1)) begin
                    st_nxt  = RSC_ST_RUN;
                    cnt_nxt = 32'h0;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            RSC_ST_RUN: begin
                if (any_src) begin
                    st_nxt  = RSC_ST_HOLD;
                    cnt_nxt = 32'h0;
                end
            end
            default: begin
                st_nxt  = RSC_ST_HOLD;
                cnt_nxt = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r       <= RSC_ST_HOLD;
            cnt_r      <= 32'h0;
            por_seen_r <= 1'b1;
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            // delays only follow power-on and brown-out; other resets release fast
            if (rsc_power_loss(src_i)) begin
                por_seen_r <= 1'b1;
            end else if (st_r == RSC_ST_RUN) begin
                por_seen_r <= 1'b0;
            end
        end
    end

    // the request itself also drives the output so no cycle is lost
    assign master_system_reset_o = any_src || (st_r != RSC_ST_RUN);

    // reset-time oscillator pick, latched while reset is held
    always_comb begin
        osc_nxt = osc_r;
        if (!clk_switch_en_i) begin
            if (any_src) osc_nxt = new_osc_i;
        end else if (rsc_power_loss(src_i)) begin
            osc_nxt = new_osc_i;
        end else if (any_src) begin
            osc_nxt = cur_osc_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_r <= RSC_OSC_RST;
        end else begin
            osc_r <= osc_nxt;
        end
    end
    assign sys_osc_o = osc_r;

    assign watchdog_enable_o     = wdt_fuse_i | cause_r[RSC_B_SOFT_WATCHDOG_ENABLE];
    assign flash_bias_in_sleep_o = cause_r[RSC_B_FBIAS];
    assign regulator_standby_o   = ~cause_r[RSC_B_FBIAS];

    assign rd_mux = (addr_i == RSC_ADDR_CAUSE)  ? (cause_r & RSC_CAUSE_IMPL) :
                    (addr_i == RSC_ADDR_CLKSEL) ? {13'h0, osc_r} : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end

    chk_trap_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.trap && !src_i.por |=> cause_r[RSC_B_TRAP])
        else $error("trap flag not set");
    chk_illop_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_i.illop || src_i.uninit_wreg_reset) && !src_i.por |=> cause_r[RSC_B_ILLOP])
        else $error("illegal op flag not set");
    chk_pin_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.pin && !src_i.por |=> cause_r[RSC_B_PIN])
        else $error("pin flag not set");
    chk_por_value: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.por |=> cause_r == RSC_CAUSE_POR_VAL)
        else $error("power-on value wrong");
    chk_reset_any_src: assert property (@(posedge clk_i) disable iff (rst_i)
        any_src |-> master_system_reset_o)
        else $error("reset not active with source");
    chk_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rd_i) |-> rdata_o[13:11] == 3'h0)
        else $error("unimplemented bits nonzero");
    chk_wdt_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        wdt_fuse_i |-> watchdog_enable_o)
        else $error("fuse did not force watchdog");
    chk_dslp_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
        !cause_r[RSC_B_DSLP] && !(psave_i.sleep && psave_i.deep_en) |=> !cause_r[RSC_B_DSLP])
        else $error("deep sleep flag set by software");
    chk_watchdog_timeout_flag_psave_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        psave_i.idle && !src_i.watchdog_timeout_flag |=> !cause_r[RSC_B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not cleared");
    chk_osc_current: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_switch_en_i && src_i.pin && !src_i.por && !src_i.bor |=> osc_r == $past(cur_osc_i))
        else $error("current oscillator not kept");

    // quiet cycles since the last source, and whether a power loss armed the delays
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet_cnt_r <= 32'h0;
            arm_r       <= 1'b1;
        end else begin
            quiet_cnt_r <= any_src ? 32'h0 : quiet_cnt_r + 32'h1;
            if (rsc_power_loss(src_i)) begin
                arm_r <= 1'b1;
            end else if (!master_system_reset_o) begin
                arm_r <= 1'b0;
            end
        end
    end

    // cause flags: each source leaves its own mark one cycle later

    chk_cfgmm_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.cfgmm && !src_i.por
        |=> cause_r[RSC_B_CFGMM])
        else $error("config mismatch flag not set");

    chk_swrst_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.swrst && !src_i.por
        |=> cause_r[RSC_B_SWRST])
        else $error("software reset flag not set");

    chk_watchdog_timeout_flag_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.watchdog_timeout_flag && !src_i.por
        |=> cause_r[RSC_B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not set");

    chk_sleep_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        psave_i.sleep && !src_i.por
        |=> cause_r[RSC_B_SLEEP])
        else $error("sleep flag not set");

    chk_idle_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        psave_i.idle && !src_i.por
        |=> cause_r[RSC_B_IDLE])
        else $error("idle flag not set");

    chk_dslp_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        psave_i.sleep && psave_i.deep_en && !src_i.por
        |=> cause_r[RSC_B_DSLP])
        else $error("deep sleep flag not set");

    chk_bor_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        src_i.bor
        |=> cause_r[RSC_B_BOR])
        else $error("brown-out flag not set");

    // only software may clear the two power flags; no reset source does

    chk_bor_flag_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        cause_r[RSC_B_BOR] && !wr_cause
        |=> cause_r[RSC_B_BOR])
        else $error("brown-out flag lost");

    chk_por_flag_only: assert property (@(posedge clk_i) disable iff (rst_i)
        !cause_r[RSC_B_POR] && !src_i.por && !wr_cause
        |=> !cause_r[RSC_B_POR])
        else $error("power-on flag set without power-on");

    chk_por_flag_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        cause_r[RSC_B_POR] && !wr_cause
        |=> cause_r[RSC_B_POR])
        else $error("power-on flag lost");

    // software port: a write lands and never starts a reset by itself

    chk_sw_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cause && !src_i.por && !src_i.pin
        |=> cause_r[RSC_B_PIN] == $past(wdata_i[RSC_B_PIN]))
        else $error("software write lost");

    chk_sw_no_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cause && !any_src && st_r == RSC_ST_RUN
        |=> st_r == RSC_ST_RUN)
        else $error("software write caused a reset");

    chk_cause_impl: assert property (@(posedge clk_i) disable iff (rst_i)
        cause_r[13:11] == 3'h0)
        else $error("unimplemented cause bits set");

    chk_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rd_i)
        |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");

    chk_wdt_soft: assert property (@(posedge clk_i) disable iff (rst_i)
        !wdt_fuse_i
        |-> watchdog_enable_o == cause_r[RSC_B_SOFT_WATCHDOG_ENABLE])
        else $error("soft watchdog enable not followed");

    chk_fbias_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        flash_bias_in_sleep_o == cause_r[RSC_B_FBIAS]
        && regulator_standby_o == !cause_r[RSC_B_FBIAS])
        else $error("flash bias or standby wrong");

    // reset-time oscillator pick

    chk_osc_new_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_switch_en_i && rsc_power_loss(src_i)
        |=> osc_r == $past(new_osc_i))
        else $error("new oscillator field not taken");

    chk_osc_noswitch: assert property (@(posedge clk_i) disable iff (rst_i)
        !clk_switch_en_i && any_src
        |=> osc_r == $past(new_osc_i))
        else $error("configured oscillator not taken");

    // release sequencing: held with a source, released late after a power loss

    chk_hold_with_src: assert property (@(posedge clk_i) disable iff (rst_i)
        any_src
        |=> st_r == RSC_ST_HOLD)
        else $error("sequencer left hold with a source");

    chk_release_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !any_src && st_r == RSC_ST_RUN
        |-> !master_system_reset_o)
        else $error("master reset stuck in run");

    chk_por_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        arm_r && !master_system_reset_o
        |-> quiet_cnt_r >= 32'(TPOR_CYC))
        else $error("released before power-on delay");

    chk_power_up_timer_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        arm_r && power_up_timer_en_i && !master_system_reset_o
        |-> quiet_cnt_r >= 32'(TPOR_CYC + TPWRT_CYC))
        else $error("released before power-up timer");

    cov_pin_reset: cover property (@(posedge clk_i) disable iff (rst_i)
        src_i.pin ##[1:40] !master_system_reset_o);
    cov_power_up_timer_phase: cover property (@(posedge clk_i) disable iff (rst_i) power_up_timer_phase);
    cov_brownout: cover property (@(posedge clk_i) disable iff (rst_i) src_i.bor);
    cov_deep_sleep: cover property (@(posedge clk_i) disable iff (rst_i)
        psave_i.sleep && psave_i.deep_en);
    cov_sw_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_cause);
endmodule // rsc_combiner
`default_nettype wire

// ===== dv/rsc_src_model.sv
// reset-request sources and cpu power-save model driving the combiner
// assumes one clk_i domain; the bench pulses go_i to launch a request
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model
    import rsc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   go_i,
    input  wire logic [8:0] src_req_i,
    input  wire logic [2:0] ps_req_i,
    input  wire logic [3:0] len_i,
    output rsc_src_s    src_o,
    output rsc_psave_s  psave_o
);
    logic [3:0] cnt_r;
    logic [8:0] hold_r;
    // sources stay up for len_i cycles so long requests can be held
    assign src_o = (cnt_r != 4'h0) ? hold_r : 9'h000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r   <= 4'h0;
            hold_r  <= 9'h000;
            psave_o <= '0;
        end else if (go_i) begin
            cnt_r   <= len_i;
            hold_r  <= src_req_i;
            psave_o <= ps_req_i;
        end else begin
            // instruction strobes last one cycle; deep-sleep enable is a level
            psave_o.sleep <= 1'b0;
            psave_o.idle  <= 1'b0;
            if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule // rsc_src_model
`default_nettype wire

// ===== dv/reset_source_combiner_tb.sv
// self-checking bench for the reset source combiner
// assumes short por and power-up counts so release comes within tens of cycles
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner_tb;
    import rsc_pkg::*;
    typedef struct packed {
        logic [8:0]  s;
        logic [2:0]  p;
        logic [15:0] cause;
    } rsc_row_s;
    logic clk_i = 0, rst_i = 1, go = 0, sw_en = 1, fuse = 0, wr = 0, rd = 0;
    logic [8:0]  sreq = '0;
    logic [2:0]  preq = '0, osc;
    logic [3:0]  len = 4'h1, addr = 4'h0;
    logic [15:0] wdata = '0, rdo, got;
    logic        msr, wen, fb, rsb;
    rsc_src_s    src;
    rsc_psave_s  ps;
    int n_mismatch = 0, samples_checked = 0;
    rsc_row_s rows [12] = '{
        '{9'h040, 3'h0, 16'h0080}, '{9'h020, 3'h0, 16'h0040},
        '{9'h010, 3'h0, 16'h0010}, '{9'h008, 3'h0, 16'h0200},
        '{9'h004, 3'h0, 16'h8000}, '{9'h002, 3'h0, 16'h4000},
        '{9'h001, 3'h0, 16'h4000}, '{9'h080, 3'h0, 16'h0002},
        '{9'h100, 3'h0, 16'h0003}, '{9'h000, 3'h4, 16'h0008},
        '{9'h000, 3'h2, 16'h0004}, '{9'h000, 3'h5, 16'h0408}};
    always #50 clk_i = ~clk_i;
    rsc_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .src_req_i(sreq),
        .ps_req_i(preq), .len_i(len), .src_o(src), .psave_o(ps));
    rsc_combiner #(.TPOR_CYC(4), .TPWRT_CYC(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .src_i(src), .psave_i(ps), .power_up_timer_en_i(1'b1), .wdt_fuse_i(fuse),
        .clk_switch_en_i(sw_en), .new_osc_i(3'h5), .cur_osc_i(3'h2), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdo),
        .master_system_reset_o(msr), .watchdog_enable_o(wen),
        .flash_bias_in_sleep_o(fb), .regulator_standby_o(rsb), .sys_osc_o(osc));
    task automatic chk_word(input logic [15:0] exp, input logic [15:0] act);
        samples_checked++;
        if (act !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t word exp %h got %h", $time, exp, act);
        end
    endtask
    task automatic chk_bit(input logic exp, input logic act);
        samples_checked++;
        if (act !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t bit exp %b got %b", $time, exp, act);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_i);
        addr <= a; rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        got = rdo;
    endtask
    task automatic fire(input logic [8:0] s, input logic [2:0] p, input logic [3:0] n);
        @(posedge clk_i);
        sreq <= s; preq <= p; len <= n; go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(negedge clk_i);
        chk_bit(s != 9'h000, msr);
    endtask
    // bounded wait: a reset that never releases must not hang the run
    task automatic wait_rel();
        for (int i = 0; i < 40 && msr !== 1'b0; i++) @(negedge clk_i);
        if (msr !== 1'b0) begin
            n_mismatch++;
            $display("mismatch t=%0t master reset stuck", $time);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        $display("mismatch t=%0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(negedge clk_i);
        chk_bit(1'b1, msr);
        wait_rel();
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'h0003, got);
        foreach (rows[i]) begin
            wr_reg(RSC_ADDR_CAUSE, 16'h0000);
            fire(rows[i].s, rows[i].p, 4'h1);
            wait_rel();
            rd_reg(RSC_ADDR_CAUSE); chk_word(rows[i].cause, got);
            if (rows[i].s != 9'h000)
                chk_word({13'h0, (rows[i].s[8] | rows[i].s[7]) ? 3'h5 : 3'h2}, {13'h0, osc});
        end
        wr_reg(RSC_ADDR_CAUSE, 16'h0000);
        wr_reg(RSC_ADDR_CAUSE, 16'hffff);
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'hc3ff, got);
        chk_bit(1'b0, msr);
        chk_bit(1'b1, wen);
        chk_bit(1'b1, fb); chk_bit(1'b0, rsb);
        wr_reg(RSC_ADDR_CAUSE, 16'h0000);
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'h0000, got);
        chk_bit(1'b0, wen); chk_bit(1'b0, fb); chk_bit(1'b1, rsb);
        @(posedge clk_i);
        fuse <= 1'b1;
        @(negedge clk_i);
        chk_bit(1'b1, wen);
        wr_reg(RSC_ADDR_CAUSE, 16'h0010);
        fire(9'h000, 3'h2, 4'h1);
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'h0004, got);
        // second power-on mid-run; its flags must survive a later pin reset
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_rel();
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'h0003, got);
        fire(9'h040, 3'h0, 4'h1);
        wait_rel();
        rd_reg(RSC_ADDR_CAUSE); chk_word(16'h0083, got);
        fire(9'h040, 3'h0, 4'h6);
        repeat (4) @(negedge clk_i);
        chk_bit(1'b1, msr);
        wait_rel();
        @(posedge clk_i);
        sw_en <= 1'b0;
        fire(9'h040, 3'h0, 4'h1);
        wait_rel();
        chk_word(16'h0005, {13'h0, osc});
        rd_reg(4'hf); chk_word(16'h0000, got);
        end_of_test();
    end
endmodule // reset_source_combiner_tb
`default_nettype wire
